// ---- logic/tpsir_pkg.sv ----
package tpsir_pkg;
	// Register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SUMMARY = 8'h02;
	localparam logic [7:0] OFS_PADS = 8'h03;
	localparam logic [7:0] OFS_LAMPS = 8'h04;
	localparam logic [7:0] OFS_DUTY_PULSE2 = 8'h91;
	localparam logic [7:0] OFS_DUTY_BREATHE = 8'h92;
	localparam logic [7:0] OFS_DUTY_DIRECT = 8'h93;
	localparam logic [7:0] OFS_RAMP = 8'h94;
	localparam logic [7:0] OFS_OFF_DELAY = 8'h95;
	localparam logic [7:0] OFS_CAL1 = 8'hb1;
	localparam logic [7:0] OFS_CAL2 = 8'hb2;
	localparam logic [7:0] OFS_CAL3 = 8'hb3;
	localparam logic [7:0] OFS_CAL_LOW = 8'hb9;
	localparam logic [7:0] OFS_PART_ID = 8'hfd;
	localparam logic [7:0] OFS_VENDOR_ID = 8'hfe;
	localparam logic [7:0] OFS_REVISION = 8'hff;

	// Control register fields
	localparam int CTRL_GAIN_HI = 7;
	localparam int CTRL_GAIN_LO = 6;
	localparam int CTRL_STANDBY = 5;
	localparam int CTRL_DEEPEST_IDLE_ENABLE = 4;
	localparam int CTRL_INT = 0;

	// Summary register fields
	localparam int SUM_LAMP = 4;
	localparam int SUM_MANY = 2;
	localparam int SUM_PATTERN = 1;
	localparam int SUM_TOUCH = 0;

	// Reset values
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_DUTY = 8'hf0;
	localparam logic [7:0] RST_RAMP = 8'h00;
	localparam logic [7:0] RST_OFF_DELAY = 8'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	localparam logic [3:0] RST_GAIN = 4'h1;
	localparam logic [2:0] RST_SCAN = 3'h7;

	// Identification values, arbitrary
	localparam logic [7:0] ID_PART = 8'h11;
	localparam logic [7:0] ID_VENDOR = 8'h22;
	localparam logic [7:0] ID_REVISION = 8'h01;

	// Events from the sensing core and LED engine
	typedef struct packed {
		logic [2:0] touch;
		logic [2:0] lamp_done;
		logic many_press;
		logic pattern;
	} tpsir_core_t;

	// Settings handed to the LED engine
	typedef struct packed {
		logic [7:0] duty_pulse2;
		logic [7:0] duty_breathe;
		logic [7:0] duty_direct;
		logic [7:0] ramp_rates;
		logic [7:0] off_delay;
	} tpsir_lamp_cfg_t;
endpackage

// ---- logic/tpsir_flags.sv ----
module tpsir_flags (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// Mode and host actions
	input wire logic standby,
	input wire logic deepest_idle_enable,
	input wire logic int_clear,
	input wire logic pads_read,
	// Events and enables
	input wire tpsir_pkg::tpsir_core_t core,
	input wire logic [2:0] scan_mask,
	input wire logic [2:0] ch_irq_en,
	input wire logic pattern_irq_en,
	// Status
	output logic int_flag,
	output logic [2:0] pads,
	output logic [2:0] lamps,
	output logic pattern,
	output logic many,
	output logic [2:0] release_pulse
);
	logic int_reg, int_next;
	logic [2:0] pads_reg, pads_next;
	logic [2:0] lamps_reg, lamps_next;
	logic [2:0] prev_reg;
	logic [2:0] rel_reg;
	logic pattern_reg, many_reg, deepest_idle_enable_prev_reg;
	logic read_seen_reg, read_seen_next;

	wire [2:0] touch_eff = deepest_idle_enable ? 3'h0 : (core.touch & scan_mask);
	wire [2:0] new_touch = touch_eff & ~prev_reg;
	wire [2:0] lamp_in = deepest_idle_enable ? 3'h0 : core.lamp_done;
	wire pattern_eff = ~deepest_idle_enable & core.pattern;
	wire many_eff = ~deepest_idle_enable & core.many_press;
	wire deepest_idle_enable_entry = deepest_idle_enable & ~deepest_idle_enable_prev_reg;
	// In standby a clear releases the pads only after they have been read
	wire clear_ok = int_clear & (~standby | read_seen_reg);
	wire [2:0] pad_clr = clear_ok ? ~touch_eff : 3'h0;
	// Many-press never raises the flag
	wire int_set = |(new_touch & ch_irq_en) | (pattern_eff & ~pattern_reg & pattern_irq_en)
		| (|lamp_in);

	// Set wins over a host clear
	assign int_next = deepest_idle_enable_entry ? 1'b0 : (int_set | (int_reg & ~int_clear));
	assign pads_next = deepest_idle_enable_entry ? 3'h0 : (touch_eff | (pads_reg & ~pad_clr));
	assign lamps_next = deepest_idle_enable_entry ? 3'h0 : (lamp_in | (lamps_reg & ~{3{int_clear}}));
	assign read_seen_next = pads_read | (read_seen_reg & ~clear_ok & ~deepest_idle_enable_entry);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			int_reg <= 1'b0;
			pads_reg <= 3'h0;
			lamps_reg <= 3'h0;
			prev_reg <= 3'h0;
			rel_reg <= 3'h0;
			pattern_reg <= 1'b0;
			many_reg <= 1'b0;
			deepest_idle_enable_prev_reg <= 1'b0;
			read_seen_reg <= 1'b0;
		end else if (ce) begin
			int_reg <= int_next;
			pads_reg <= pads_next;
			lamps_reg <= lamps_next;
			prev_reg <= touch_eff;
			rel_reg <= prev_reg & ~touch_eff;
			pattern_reg <= pattern_eff;
			many_reg <= many_eff;
			deepest_idle_enable_prev_reg <= deepest_idle_enable;
			read_seen_reg <= read_seen_next;
		end
	end

	assign int_flag = int_reg;
	assign pads = pads_reg;
	assign lamps = lamps_reg;
	assign pattern = pattern_reg;
	assign many = many_reg;
	assign release_pulse = rel_reg;
endmodule

// ---- logic/tpsir_top.sv ----
module tpsir_top (
	// Clock, reset, enable
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire logic CE,
	// Register port from serial front end
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	// Sensing core and LED engine
	input wire tpsir_pkg::tpsir_core_t CORE_EVENTS,
	input wire logic [29:0] CAL_VALUES,
	// Settings kept by neighbouring registers
	input wire logic [2:0] CH_IRQ_EN,
	input wire logic PATTERN_IRQ_EN,
	input wire logic [2:0] STANDBY_CH_SEL,
	// Control towards core and LEDs
	output logic [3:0] GAIN_MANY_PRESS_BLOCK_FLAG,
	output logic [2:0] SCAN_ENABLE,
	output logic [2:0] PAD_RELEASE,
	output logic LED_FORCE_INACTIVE,
	output logic PWM_HALT,
	output tpsir_pkg::tpsir_lamp_cfg_t LAMP_CFG,
	// Alert pin
	output logic ALERT_N_OUT,
	output logic ALERT_N_OE
);
	logic [7:0] ctrl_reg;
	logic [7:0] duty_p2_reg, duty_br_reg, duty_dir_reg, ramp_reg, off_dly_reg;
	logic [7:0] rdata_reg;
	logic [3:0] gain_reg;
	logic [2:0] scan_reg;
	logic sleep_out_reg;
	logic int_flag, pattern, many;
	logic [2:0] pads, lamps, release_pulse;

	// Address decode
	wire hit_ctrl = (REG_ADDR == tpsir_pkg::OFS_CTRL);
	wire hit_sum = (REG_ADDR == tpsir_pkg::OFS_SUMMARY);
	wire hit_pads = (REG_ADDR == tpsir_pkg::OFS_PADS);
	wire hit_lamps = (REG_ADDR == tpsir_pkg::OFS_LAMPS);
	wire hit_dp2 = (REG_ADDR == tpsir_pkg::OFS_DUTY_PULSE2);
	wire hit_dbr = (REG_ADDR == tpsir_pkg::OFS_DUTY_BREATHE);
	wire hit_ddir = (REG_ADDR == tpsir_pkg::OFS_DUTY_DIRECT);
	wire hit_ramp = (REG_ADDR == tpsir_pkg::OFS_RAMP);
	wire hit_odly = (REG_ADDR == tpsir_pkg::OFS_OFF_DELAY);
	wire hit_cal1 = (REG_ADDR == tpsir_pkg::OFS_CAL1);
	wire hit_cal2 = (REG_ADDR == tpsir_pkg::OFS_CAL2);
	wire hit_cal3 = (REG_ADDR == tpsir_pkg::OFS_CAL3);
	wire hit_call = (REG_ADDR == tpsir_pkg::OFS_CAL_LOW);
	wire hit_part = (REG_ADDR == tpsir_pkg::OFS_PART_ID);
	wire hit_vend = (REG_ADDR == tpsir_pkg::OFS_VENDOR_ID);
	wire hit_rev = (REG_ADDR == tpsir_pkg::OFS_REVISION);
	wire mapped = hit_ctrl | hit_sum | hit_pads | hit_lamps | hit_dp2 | hit_dbr | hit_ddir
		| hit_ramp | hit_odly | hit_cal1 | hit_cal2 | hit_cal3 | hit_call | hit_part
		| hit_vend | hit_rev;

	// Write strobes, unmapped writes fall through
	wire wr_ctrl = REG_WR & hit_ctrl;
	wire wr_dp2 = REG_WR & hit_dp2;
	wire wr_dbr = REG_WR & hit_dbr;
	wire wr_ddir = REG_WR & hit_ddir;
	wire wr_ramp = REG_WR & hit_ramp;
	wire wr_odly = REG_WR & hit_odly;
	wire int_clear = wr_ctrl & ~REG_WDATA[tpsir_pkg::CTRL_INT];
	wire pads_read = REG_RD & hit_pads;

	wire standby = ctrl_reg[tpsir_pkg::CTRL_STANDBY];
	wire deepest_idle_enable = ctrl_reg[tpsir_pkg::CTRL_DEEPEST_IDLE_ENABLE];
	wire [1:0] gain_code = ctrl_reg[tpsir_pkg::CTRL_GAIN_HI:tpsir_pkg::CTRL_GAIN_LO];

	// Status views
	wire [7:0] ctrl_view = {ctrl_reg[7:1], int_flag};
	wire [7:0] sum_view = {3'h0, |lamps, 1'b0, many, pattern, |pads};
	wire [7:0] pads_view = {5'h0, pads};
	wire [7:0] lamps_view = {5'h0, lamps};
	// Calibration readback, high bytes and packed low pairs
	wire [7:0] cal1_view = CAL_VALUES[9:2];
	wire [7:0] cal2_view = CAL_VALUES[19:12];
	wire [7:0] cal3_view = CAL_VALUES[29:22];
	wire [7:0] cal_low_view = {2'h0, CAL_VALUES[21:20], CAL_VALUES[11:10], CAL_VALUES[1:0]};

	// Read selection, zero when nothing matches
	wire [7:0] rd_mux = ({8{hit_ctrl}} & ctrl_view)
		| ({8{hit_sum}} & sum_view)
		| ({8{hit_pads}} & pads_view)
		| ({8{hit_lamps}} & lamps_view)
		| ({8{hit_dp2}} & duty_p2_reg)
		| ({8{hit_dbr}} & duty_br_reg)
		| ({8{hit_ddir}} & duty_dir_reg)
		| ({8{hit_ramp}} & ramp_reg)
		| ({8{hit_odly}} & off_dly_reg)
		| ({8{hit_cal1}} & cal1_view)
		| ({8{hit_cal2}} & cal2_view)
		| ({8{hit_cal3}} & cal3_view)
		| ({8{hit_call}} & cal_low_view)
		| ({8{hit_part}} & tpsir_pkg::ID_PART)
		| ({8{hit_vend}} & tpsir_pkg::ID_VENDOR)
		| ({8{hit_rev}} & tpsir_pkg::ID_REVISION);

	// Control register; the flag bit itself lives in the flag logic
	wire [7:0] ctrl_next = wr_ctrl ? {REG_WDATA[7:4], 4'h0} : ctrl_reg;
	wire [3:0] gain_next = 4'h1 << ctrl_next[tpsir_pkg::CTRL_GAIN_HI:tpsir_pkg::CTRL_GAIN_LO];
	wire deepest_idle_enable_next = ctrl_next[tpsir_pkg::CTRL_DEEPEST_IDLE_ENABLE];
	wire [2:0] scan_next = deepest_idle_enable_next ? 3'h0
		: (ctrl_next[tpsir_pkg::CTRL_STANDBY] ? STANDBY_CH_SEL : tpsir_pkg::RST_SCAN);

	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			ctrl_reg <= tpsir_pkg::RST_CTRL;
			gain_reg <= tpsir_pkg::RST_GAIN;
			scan_reg <= tpsir_pkg::RST_SCAN;
			sleep_out_reg <= 1'b0;
		end else if (CE) begin
			ctrl_reg <= ctrl_next;
			gain_reg <= gain_next;
			scan_reg <= scan_next;
			sleep_out_reg <= deepest_idle_enable_next;
		end
	end

	// LED settings, untouched by standby
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			duty_p2_reg <= tpsir_pkg::RST_DUTY;
			duty_br_reg <= tpsir_pkg::RST_DUTY;
			duty_dir_reg <= tpsir_pkg::RST_DUTY;
			ramp_reg <= tpsir_pkg::RST_RAMP;
			off_dly_reg <= tpsir_pkg::RST_OFF_DELAY;
		end else if (CE) begin
			if (wr_dp2) begin
				duty_p2_reg <= REG_WDATA;
			end
			if (wr_dbr) begin
				duty_br_reg <= REG_WDATA;
			end
			if (wr_ddir) begin
				duty_dir_reg <= REG_WDATA;
			end
			if (wr_ramp) begin
				ramp_reg <= REG_WDATA;
			end
			if (wr_odly) begin
				off_dly_reg <= REG_WDATA;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			rdata_reg <= tpsir_pkg::RD_UNMAPPED;
		end else if (CE && REG_RD) begin
			rdata_reg <= rd_mux;
		end
	end

	tpsir_flags u_flags (
		.clk(CORE_CLK),
		.resetn(RESETN),
		.ce(CE),
		.standby(standby),
		.deepest_idle_enable(deepest_idle_enable),
		.int_clear(int_clear),
		.pads_read(pads_read),
		.core(CORE_EVENTS),
		.scan_mask(scan_reg),
		.ch_irq_en(CH_IRQ_EN),
		.pattern_irq_en(PATTERN_IRQ_EN),
		.int_flag(int_flag),
		.pads(pads),
		.lamps(lamps),
		.pattern(pattern),
		.many(many),
		.release_pulse(release_pulse)
	);

	assign REG_RDATA = rdata_reg;
	assign GAIN_MANY_PRESS_BLOCK_FLAG = gain_reg;
	assign SCAN_ENABLE = scan_reg;
	assign PAD_RELEASE = release_pulse;
	// Standby never forces LEDs; only deep sleep does
	assign LED_FORCE_INACTIVE = sleep_out_reg;
	assign PWM_HALT = sleep_out_reg;
	assign LAMP_CFG = {duty_p2_reg, duty_br_reg, duty_dir_reg, ramp_reg, off_dly_reg};
	// Open drain: pull low while pending
	assign ALERT_N_OUT = 1'b0;
	assign ALERT_N_OE = int_flag;

	// Checks
	// No enabled source active this cycle
	wire quiet_sources = ((CORE_EVENTS.touch & CH_IRQ_EN) == 3'h0) && !PATTERN_IRQ_EN
		&& (CORE_EVENTS.lamp_done == 3'h0);

	sequence seq_wr_ctrl;
		CE && wr_ctrl;
	endsequence

	sequence seq_sleep_on;
		CE && !deepest_idle_enable ##1 CE && deepest_idle_enable;
	endsequence

	AST_RESET_DEFAULTS: assert property (@(posedge CORE_CLK)
		!RESETN |=> ctrl_reg == tpsir_pkg::RST_CTRL && duty_p2_reg == tpsir_pkg::RST_DUTY
			&& duty_dir_reg == tpsir_pkg::RST_DUTY && !int_flag && REG_RDATA == 8'h00)
		else $error("Defaults not loaded by reset");

	AST_UNMAPPED_READ: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		CE && REG_RD && !mapped |=> REG_RDATA == tpsir_pkg::RD_UNMAPPED)
		else $error("Unmapped read returned nonzero");

	AST_UNMAPPED_WRITE: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		CE && REG_WR && !mapped |=> $stable(ctrl_reg) && $stable(LAMP_CFG))
		else $error("Unmapped write changed state");

	AST_GAIN_DECODE: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		seq_wr_ctrl |=> GAIN_MANY_PRESS_BLOCK_FLAG == (4'h1 << $past(REG_WDATA[7:6])))
		else $error("Gain decode wrong");

	AST_GAIN_ALL_STATES: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		##1 GAIN_MANY_PRESS_BLOCK_FLAG == (4'h1 << gain_code))
		else $error("Gain not applied in this state");

	AST_STANDBY_SCAN: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		CE && standby && !deepest_idle_enable && !wr_ctrl ##1 CE |-> SCAN_ENABLE == $past(STANDBY_CH_SEL))
		else $error("Standby scans wrong inputs");

	AST_STANDBY_HOLD: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		CE && standby && pads != 3'h0 && !u_flags.read_seen_reg && !deepest_idle_enable
			&& !u_flags.deepest_idle_enable_entry |=> pads != 3'h0)
		else $error("Standby status cleared before read");

	AST_STANDBY_LEDS: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		CE && standby && !deepest_idle_enable && !wr_ctrl ##1 CE |-> !LED_FORCE_INACTIVE && !PWM_HALT)
		else $error("LEDs disturbed outside deep sleep");

	AST_RELEASE_ONCE: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		CE && PAD_RELEASE[0] ##1 CE |-> !PAD_RELEASE[0])
		else $error("Release reported twice");

	AST_SLEEP_OUTPUTS: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		CE && deepest_idle_enable && !wr_ctrl ##1 CE |-> SCAN_ENABLE == 3'h0 && LED_FORCE_INACTIVE && PWM_HALT)
		else $error("Deep sleep outputs wrong");

	AST_SLEEP_CLEARS: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		seq_sleep_on |=> !int_flag && pads == 3'h0 && lamps == 3'h0 && !pattern && !many)
		else $error("Deep sleep entry left status set");

	AST_ALERT_PIN: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		$rose(int_flag) |-> ALERT_N_OE && !ALERT_N_OUT)
		else $error("Alert not asserted with flag");

	AST_MASKED_SILENT: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		CE && !int_flag && quiet_sources |=> !int_flag)
		else $error("Flag raised by masked or many-press event");

	AST_HOST_CLEAR: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		CE && int_clear && quiet_sources |=> !int_flag && !ALERT_N_OE)
		else $error("Host clear did not release alert");

	AST_LAMP_SUMMARY: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		sum_view[tpsir_pkg::SUM_LAMP] == (lamps != 3'h0))
		else $error("Lamp summary mismatch");

	AST_MANY_SILENT: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		CE && !int_flag && quiet_sources && CORE_EVENTS.many_press |=> !int_flag)
		else $error("Many-press raised flag");

	AST_PATTERN_GATED: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		CE && !int_flag && !PATTERN_IRQ_EN && ((CORE_EVENTS.touch & CH_IRQ_EN) == 3'h0)
			&& (CORE_EVENTS.lamp_done == 3'h0) && CORE_EVENTS.pattern |=> !int_flag)
		else $error("Pattern raised flag while disabled");

	AST_PATTERN_HOLD: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		CE && pattern && CORE_EVENTS.pattern && !deepest_idle_enable |=> pattern)
		else $error("Pattern bit dropped early");

	AST_TOUCH_SUMMARY: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		sum_view[tpsir_pkg::SUM_TOUCH] == (pads != 3'h0))
		else $error("Touch summary mismatch");

	AST_ID_READ: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		CE && REG_RD && hit_vend |=> REG_RDATA == tpsir_pkg::ID_VENDOR)
		else $error("Identity read wrong");

	AST_CAL_READ: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		CE && REG_RD && hit_cal2 |=> REG_RDATA == $past(CAL_VALUES[19:12]))
		else $error("Calibration read wrong");

	AST_PAD_PERSIST: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		CE && pads[0] && CORE_EVENTS.touch[0] && SCAN_ENABLE[0] && !deepest_idle_enable |=> pads[0])
		else $error("Pad flag cleared while touched");

	AST_LAMP_CLEAR: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		CE && int_clear && !deepest_idle_enable && CORE_EVENTS.lamp_done == 3'h0 |=> lamps == 3'h0)
		else $error("Lamp bits not cleared");

	AST_RESET_OUTPUTS: assert property (@(posedge CORE_CLK)
		!RESETN |=> GAIN_MANY_PRESS_BLOCK_FLAG == tpsir_pkg::RST_GAIN && SCAN_ENABLE == tpsir_pkg::RST_SCAN
			&& !LED_FORCE_INACTIVE && !PWM_HALT && !ALERT_N_OE)
		else $error("Control outputs not reset");

	AST_ACTIVE_SCAN: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		CE && !standby && !deepest_idle_enable && !wr_ctrl |=> SCAN_ENABLE == tpsir_pkg::RST_SCAN)
		else $error("Active state scans wrong inputs");

	AST_TOUCH_RAISES: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		CE && (|(CORE_EVENTS.touch & SCAN_ENABLE & CH_IRQ_EN & ~u_flags.prev_reg)) && !deepest_idle_enable
			|=> int_flag && ALERT_N_OE)
		else $error("Enabled touch did not raise alert");

	AST_PAD_SET: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		CE && CORE_EVENTS.touch[1] && SCAN_ENABLE[1] && !deepest_idle_enable
			|=> pads[1] && sum_view[tpsir_pkg::SUM_TOUCH])
		else $error("Scanned touch not flagged");

	AST_LAMP_RAISES: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		CE && !deepest_idle_enable && (CORE_EVENTS.lamp_done != 3'h0)
			|=> int_flag && sum_view[tpsir_pkg::SUM_LAMP])
		else $error("Lamp done not flagged");
endmodule

// ---- testbench/tpsir_host_model.sv ----
module tpsir_host_model (
	// Clock
	input wire logic clk,
	// Register strobe port
	output logic wr,
	output logic rd,
	output logic [7:0] addr,
	output logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
	end

	// Clearing the pending flag is done by writing zero to bit 0
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk);
		#1;
		wr = 1'b0;
		addr = ~a;
		wdata = ~d;
	endtask

	// Read data is valid in the cycle after the strobe edge
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		addr = a;
		rd = 1'b1;
		@(posedge clk);
		#1;
		d = rdata;
		rd = 1'b0;
		addr = ~a;
	endtask
endmodule

// ---- testbench/tpsir_test.sv ----
module tpsir_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic resetn, ce, wr, rd, pat_en, led_off, pwm_halt, alert_out, alert_oe;
	logic [7:0] addr, wdata, rdata;
	logic [29:0] cal;
	logic [2:0] irq_en, low_power_scan_enable_sel, scan, rel;
	logic [3:0] gain;
	logic [31:0] seed = 32'h6d94;
	tpsir_pkg::tpsir_core_t ev;
	tpsir_pkg::tpsir_lamp_cfg_t lamp_cfg;
	int bad_count = 0;
	int compares = 0;
	int rel_cnt = 0;
	int m_ctrl, m_pads, m_lamps, m_pat, m_many, m_read03, m_prev;
	int m_rw[int];
	int addrs[$] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h90, 8'h91, 8'h92, 8'h93,
		8'h94, 8'h95, 8'h96, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb9, 8'hfd, 8'hfe, 8'hff};

	always #5 clk = ~clk;
	always @(posedge clk) begin
		if (rel[2] === 1'b1)
			rel_cnt++;
	end

	tpsir_top dut (.CORE_CLK(clk), .RESETN(resetn), .CE(ce), .REG_WR(wr), .REG_RD(rd),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .CORE_EVENTS(ev),
		.CAL_VALUES(cal), .CH_IRQ_EN(irq_en), .PATTERN_IRQ_EN(pat_en),
		.STANDBY_CH_SEL(low_power_scan_enable_sel), .GAIN_MANY_PRESS_BLOCK_FLAG(gain), .SCAN_ENABLE(scan), .PAD_RELEASE(rel),
		.LED_FORCE_INACTIVE(led_off), .PWM_HALT(pwm_halt), .LAMP_CFG(lamp_cfg),
		.ALERT_N_OUT(alert_out), .ALERT_N_OE(alert_oe));
	tpsir_host_model host (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata),
		.rdata(rdata));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic int scan_of();
		if (m_ctrl[4])
			return 0;
		if (m_ctrl[5])
			return int'(low_power_scan_enable_sel);
		return 7;
	endfunction

	function automatic int mread(int a);
		case (a)
			8'h00: return m_ctrl;
			8'h02: return (m_lamps != 0 ? 16 : 0) + m_many * 4 + m_pat * 2 + (m_pads != 0 ? 1 : 0);
			8'h03: return m_pads;
			8'h04: return m_lamps;
			8'hb1, 8'hb2, 8'hb3: return int'(cal >> (10 * (a - 8'hb1) + 2)) & 8'hff;
			8'hb9: return int'({cal[21:20], cal[11:10], cal[1:0]});
			8'hfd: return int'(tpsir_pkg::ID_PART);
			8'hfe: return int'(tpsir_pkg::ID_VENDOR);
			8'hff: return int'(tpsir_pkg::ID_REVISION);
			default: return m_rw.exists(a) ? m_rw[a] : 0;
		endcase
	endfunction

	task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic rreg(int a);
		logic [7:0] d;
		host.read(8'(a), d);
		check($sformatf("reg %h", a), d, 8'(mread(a)));
		if (a == 3)
			m_read03 = 1;
	endtask

	task automatic wreg(int a, int d);
		logic entry;
		entry = d[4] && !m_ctrl[4];
		host.write(8'(a), 8'(d));
		if (a == 0) begin
			if (entry) begin
				m_read03 = 0;
				m_pads = 0;
				m_lamps = 0;
				m_pat = 0;
				m_many = 0;
			end else if (!d[0]) begin
				if (!m_ctrl[5] || m_read03)
					m_pads = m_pads & int'(ev.touch) & scan_of();
				m_lamps = 0;
				m_read03 = 0;
			end
			m_ctrl = (d & 8'hf0) | ((d[0] && !entry) ? (m_ctrl & 1) : 0);
			m_prev = int'(ev.touch) & scan_of();
		end else if (m_rw.exists(a)) begin
			m_rw[a] = d & 8'hff;
		end
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic apply(logic [2:0] t, logic mp, logic pt);
		int s;
		@(posedge clk);
		#1;
		ev.touch = t;
		ev.many_press = mp;
		ev.pattern = pt;
		repeat (3) @(posedge clk);
		#1;
		s = int'(t) & scan_of();
		m_pads |= s;
		if ((s & ~m_prev & int'(irq_en)) != 0 || (pt && m_pat == 0 && pat_en && !m_ctrl[4]))
			m_ctrl |= 1;
		if (!m_ctrl[4]) begin
			m_pat = pt;
			m_many = mp;
		end
		m_prev = s;
	endtask

	task automatic lamp(logic [2:0] l);
		@(posedge clk);
		#1;
		ev.lamp_done = l;
		@(posedge clk);
		#1;
		ev.lamp_done = 3'h0;
		repeat (2) @(posedge clk);
		#1;
		m_lamps |= int'(l);
		m_ctrl |= 1;
	endtask

	task automatic alert();
		check("alert_oe", {7'h00, alert_oe}, 8'(m_ctrl & 1));
		check("alert_out", {7'h00, alert_out}, 8'h00);
	endtask

	task automatic summarize();
		$display("compares %0d errors %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#100000;
		bad_count++;
		summarize();
	end

	initial begin
		resetn = 1'b0;
		ce = 1'b1;
		ev = '0;
		cal = 30'(xs());
		pat_en = 1'b0;
		irq_en = 3'h5;
		low_power_scan_enable_sel = 3'h1;
		{m_ctrl, m_pads, m_lamps, m_pat, m_many, m_read03, m_prev} = '0;
		for (int i = 8'h91; i <= 8'h95; i++)
			m_rw[i] = (i < 8'h94) ? 8'hf0 : 8'h00;
		repeat (8) @(posedge clk);
		#1;
		resetn = 1'b1;
		check("gain", {4'h0, gain}, 8'h01);
		check("scan", {5'h00, scan}, 8'h07);
		alert();
		foreach (addrs[i]) rreg(addrs[i]);
		foreach (addrs[i]) if (addrs[i] != 0) wreg(addrs[i], int'(xs()));
		foreach (addrs[i]) rreg(addrs[i]);
		for (int i = 0; i < 5; i++)
			check("lamp_cfg", lamp_cfg[39 - 8 * i -: 8], 8'(m_rw[8'h91 + i]));
		for (int g = 0; g < 4; g++) begin
			wreg(0, (g << 6) | ((g & 1) << 5));
			check("gain", {4'h0, gain}, 8'(1 << g));
			rreg(0);
		end
		wreg(0, 0);
		// Enabled touch, clear with touch held, then gone
		apply(3'h1, 0, 0);
		alert();
		rreg(2);
		wreg(0, 0);
		alert();
		rreg(3);
		apply(3'h0, 0, 0);
		alert();
		wreg(0, 0);
		rreg(3);
		apply(3'h2, 0, 0);
		alert();
		rreg(3);
		apply(3'h0, 1, 0);
		alert();
		rreg(2);
		apply(3'h0, 0, 1);
		alert();
		wreg(0, 0);
		rreg(2);
		apply(3'h0, 0, 0);
		pat_en = 1'b1;
		apply(3'h0, 0, 1);
		alert();
		apply(3'h0, 0, 0);
		wreg(0, 0);
		rreg(2);
		lamp(3'h4);
		alert();
		rreg(2);
		wreg(0, 0);
		rreg(4);
		// Standby entry drops a held touch from the scan
		apply(3'h4, 0, 0);
		wreg(0, 0);
		rel_cnt = 0;
		wreg(0, 8'h21);
		check("scan", {5'h00, scan}, {5'h00, low_power_scan_enable_sel});
		check("led_off", {6'h00, led_off, pwm_halt}, 8'h00);
		repeat (8) @(posedge clk);
		#1;
		check("release", 8'(rel_cnt), 8'h01);
		apply(3'h6, 0, 0);
		alert();
		wreg(0, 8'h20);
		rreg(3);
		wreg(0, 8'h20);
		rreg(3);
		apply(3'h0, 0, 0);
		wreg(0, 0);
		// Deep sleep entry with pending status
		apply(3'h1, 1, 1);
		wreg(0, 8'h10);
		check("scan", {5'h00, scan}, 8'h00);
		check("led_off", {6'h00, led_off, pwm_halt}, 8'h03);
		alert();
		foreach (addrs[i]) if (addrs[i] < 5) rreg(addrs[i]);
		apply(3'h2, 0, 0);
		alert();
		apply(3'h0, 0, 0);
		wreg(0, 0);
		check("scan", {5'h00, scan}, 8'h07);
		// Frozen clock enable holds every flag
		@(posedge clk);
		#1;
		ce = 1'b0;
		ev.touch = 3'h1;
		repeat (3) @(posedge clk);
		#1;
		alert();
		ev.touch = 3'h0;
		repeat (2) @(posedge clk);
		#1;
		ce = 1'b1;
		rreg(3);
		// Reset in mid-run restores the defaults
		wreg(8'h91, 8'h3c);
		wreg(0, 8'he0);
		resetn = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		resetn = 1'b1;
		m_ctrl = 0;
		m_read03 = 0;
		m_rw[8'h91] = 8'hf0;
		check("gain", {4'h0, gain}, 8'h01);
		check("scan", {5'h00, scan}, 8'h07);
		alert();
		rreg(0);
		rreg(8'h91);
		summarize();
	end
endmodule
